// ==== dram_access_refresh_controller.sv ====
// top: dram access and refresh controller with host wait support
`timescale 1ns/1ns
// Operation
// - first programming starts 60 ms self refresh
// - only first load after reset initialises
// - config word loaded on address inputs
// - mode 0 synchronous, mode 1 asynchronous RAS
// - auto, external burst, request/acknowledge refresh
// - conventional, phased or scrubbing refresh type, one at a time
// - wait output form chosen at programming
// - wait forms mode independent, extended externally
// - address latched, or passed when fall-through
// - column step increments latched column
// - one, two, four banks; byte CAS
// - separate precharge counter per bank
// - refresh clock and on-chip arbitration
// - waits guarantee RAS low and precharge
// - wait states inserted whenever needed
// - dual-port arbitration among ports, refresh
// - bank selects choose RAS/CAS groups
module dram_access_refresh_controller
    import dram_ctrl_pkg::*;
#(
    parameter int unsigned INIT_COUNT    = INIT_CYCLES,
    parameter int unsigned REFRESH_COUNT = REFRESH_INTERVAL
) (
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_srst,
    // host address and programming
    input  wire logic [ADDR_W-1:0] i_row_addr,
    input  wire logic [ADDR_W-1:0] i_col_addr,
    input  wire logic              i_bank_select_lo,
    input  wire logic              i_bank_select_hi,
    input  wire logic              i_config_load_strobe_n,
    input  wire logic              i_chip_select_n,
    // host access ports a and b
    input  wire logic              i_access_req_a,
    input  wire logic              i_access_req_b,
    input  wire logic              i_column_step_in,
    input  wire logic [3:0]        i_cas_enable_in_n,
    input  wire logic              i_wait_extend_in,
    // refresh control
    input  wire logic              i_ext_refresh_req,
    input  wire logic              i_refresh_req_in,
    output logic                   o_refresh_ack,
    // host wait outputs
    output logic                   o_transfer_ack_out,
    output logic                   o_wait_n,
    output logic                   o_grant_b,
    // dram side
    output logic [ADDR_W-1:0]      o_dram_addr,
    output logic [BANKS-1:0]       o_ras_n,
    output logic [BANKS-1:0]       o_cas_n,
    // status
    output logic                   o_programmed,
    output logic                   o_init_busy
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int unsigned NSYNC = 2 * ADDR_W + 10;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;

    // two flops on every pin before any logic reads it
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {i_row_addr, i_col_addr, i_bank_select_hi, i_bank_select_lo,
                        ~i_config_load_strobe_n, ~i_chip_select_n, i_access_req_a, i_access_req_b,
                        i_column_step_in, i_wait_extend_in, i_ext_refresh_req, i_refresh_req_in};
            sync2_q <= sync1_q;
        end
    end

    logic [ADDR_W-1:0] row_s;
    logic [ADDR_W-1:0] col_s;
    logic [1:0]        bank_s;
    logic              load_s;
    logic              cs_s;
    logic              req_a_s;
    logic              req_b_s;
    logic              step_s;
    logic              wext_s;
    logic              extref_s;
    logic              refreq_s;
    logic [3:0]        cas_enable_in_n_s;

    assign {row_s, col_s, bank_s, load_s, cs_s, req_a_s, req_b_s,
            step_s, wext_s, extref_s, refreq_s} = sync2_q;

    // byte enables pass two flops like the other inputs before they gate cas
    logic [3:0] ecas1_q;
    logic [3:0] ecas2_q;
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ecas1_q <= 4'hF;
            ecas2_q <= 4'hF;
        end else begin
            ecas1_q <= i_cas_enable_in_n;
            ecas2_q <= ecas1_q;
        end
    end
    assign cas_enable_in_n_s = ecas2_q;

    // ************************************************************
    // decoding functions
    // ************************************************************
    // configuration word sits on rows and bank selects
    function automatic cfg_t decode_cfg(input logic [ADDR_W-1:0] row, input logic [1:0] bank);
        cfg_t c;
        c.access_mode1 = row[CFG_ACCESS_MODE_BIT];
        c.ack_form     = row[CFG_WAIT_ACK_BIT];
        c.fall_through = row[CFG_FALL_THRU_BIT];
        c.auto_ref     = row[CFG_AUTO_REF_BIT];
        c.ext_ref      = row[CFG_EXT_REF_BIT];
        c.reqack_ref   = row[CFG_REQACK_REF_BIT];
        c.ref_type     = ref_type_t'(row[CFG_REF_TYPE_LSB +: 2]);
        c.bank_cfg     = bank_cfg_t'(bank);
        return c;
    endfunction

    // which ras/cas group a bank address selects under a bank configuration
    function automatic logic [BANKS-1:0] bank_group(input bank_cfg_t bc, input logic [1:0] b);
        logic [BANKS-1:0] g;
        g = '0;
        case (bc)
            BANKCFG_ONE:  g = 4'hF;
            BANKCFG_TWO:  g = b[0] ? 4'hC : 4'h3;
            default:      g = 4'(1) << b;
        endcase
        return g;
    endfunction

    // ************************************************************
    // configuration and initialisation
    // ************************************************************
    cfg_t cfg_q;
    logic programmed_q;
    logic init_busy_q;
    logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt_q;
    logic load_q;

    // load on the falling edge of the strobe; chip select has no effect
    wire load_rise = load_s & ~load_q;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            cfg_q        <= cfg_t'(CFG_RESET);
            programmed_q <= 1'b0;
            load_q       <= 1'b0;
        end else begin
            load_q <= load_s;
            if (load_rise) begin
                cfg_q        <= decode_cfg(row_s, bank_s);
                programmed_q <= 1'b1;
            end
        end
    end

    // init period starts only on the first load after reset
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            init_busy_q <= 1'b0;
            init_cnt_q  <= '0;
        end else if (load_rise && !programmed_q) begin
            init_busy_q <= 1'b1;
            init_cnt_q  <= ($bits(init_cnt_q))'(INIT_COUNT - 1);
        end else if (init_busy_q) begin
            if (init_cnt_q == '0) begin
                init_busy_q <= 1'b0;
            end else begin
                init_cnt_q <= init_cnt_q - 1'b1;
            end
        end
    end

    // ************************************************************
    // refresh request clock
    // ************************************************************
    logic [$clog2(REFRESH_INTERVAL+1)-1:0] ref_tick_q;
    logic ref_pend_q;
    logic ref_start;
    logic refreq_q;
    wire  ref_tick = (ref_tick_q == '0);

    always_ff @(posedge i_mclk) begin
        if (i_srst || !programmed_q) begin
            ref_tick_q <= ($bits(ref_tick_q))'(REFRESH_COUNT - 1);
        end else if (ref_tick) begin
            ref_tick_q <= ($bits(ref_tick_q))'(REFRESH_COUNT - 1);
        end else begin
            ref_tick_q <= ref_tick_q - 1'b1;
        end
    end

    // pending refresh; a new request beats the clearing start
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ref_pend_q <= 1'b0;
            refreq_q   <= 1'b0;
        end else begin
            refreq_q <= refreq_s;
            if ((ref_tick && (cfg_q.auto_ref || init_busy_q))
                || (cfg_q.reqack_ref && refreq_s && !refreq_q)) begin
                ref_pend_q <= 1'b1;
            end else if (ref_start) begin
                ref_pend_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // arbiter and cycle sequencer
    // ************************************************************
    typedef enum logic [2:0] { S_IDLE, S_ROW, S_COL, S_HOLD, S_REF } state_t;
    state_t state_q;
    logic [3:0] tcnt_q;
    logic [BANKS-1:0] ras_sel_q;
    logic [BANKS-1:0] prech_busy;
    logic [BANKS-1:0] prech_start;
    logic port_b_q;
    logic [1:0] phase_q;
    haddr_t addr_q;
    logic [ADDR_W-1:0] ref_row_q;
    logic step_q;

    wire ext_ref  = cfg_q.ext_ref && extref_s;
    wire want_ref = (ref_pend_q || ext_ref) && programmed_q;
    wire host_req = programmed_q && !init_busy_q && (req_a_s || req_b_s);
    wire [BANKS-1:0] req_grp = bank_group(cfg_q.bank_cfg, bank_s);
    wire req_ready = (req_grp & prech_busy) == '0;
    wire ref_ready = prech_busy == '0;

    // refresh wins contention, then port a, then port b
    assign ref_start = (state_q == S_IDLE) && want_ref && ref_ready;
    wire acc_start = (state_q == S_IDLE) && !want_ref && host_req && req_ready;
    wire cur_req   = port_b_q ? req_b_s : req_a_s;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_q   <= S_IDLE;
            tcnt_q    <= '0;
            ras_sel_q <= '0;
            port_b_q  <= 1'b0;
            phase_q   <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (ref_start) begin
                        state_q <= S_REF;
                        tcnt_q  <= 4'(RAS_LOW_CYCLES - 1);
                        phase_q <= phase_q + 2'd1;
                        // phased refresh strobes one bank per cycle type slot
                        ras_sel_q <= (cfg_q.ref_type == REF_PHASED) ? (4'(1) << phase_q) : 4'hF;
                    end else if (acc_start) begin
                        state_q   <= S_ROW;
                        port_b_q  <= !req_a_s;
                        ras_sel_q <= req_grp;
                        // mode 1 launches the row strobe at once, mode 0 waits a clock
                        tcnt_q    <= cfg_q.access_mode1 ? 4'(0) : 4'(1);
                    end
                end
                S_ROW: begin
                    if (tcnt_q == '0) begin
                        state_q <= S_COL;
                        tcnt_q  <= 4'(CAS_DELAY_CYCLES - 1);
                    end else begin
                        tcnt_q <= tcnt_q - 4'd1;
                    end
                end
                S_COL: begin
                    if (tcnt_q == '0) begin
                        state_q <= S_HOLD;
                    end else begin
                        tcnt_q <= tcnt_q - 4'd1;
                    end
                end
                S_HOLD: begin
                    if (!cur_req) begin
                        state_q   <= S_IDLE;
                        ras_sel_q <= '0;
                    end
                end
                S_REF: begin
                    if (tcnt_q == '0 && !ext_ref) begin
                        state_q   <= S_IDLE;
                        ras_sel_q <= '0;
                    end else if (tcnt_q != '0) begin
                        tcnt_q <= tcnt_q - 4'd1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ************************************************************
    // per-bank precharge counters
    // ************************************************************
    wire ending = ((state_q == S_HOLD) && !cur_req) ||
                  ((state_q == S_REF) && tcnt_q == '0 && !ext_ref);
    assign prech_start = ending ? ras_sel_q : '0;

    genvar gi;
    generate
        for (gi = 0; gi < BANKS; gi++) begin : g_prech
            precharge_counter #(
                .CYCLES (PRECHARGE_CYCLES)
            ) u_prech (
                .i_mclk  (i_mclk),
                .i_srst  (i_srst),
                .i_start (prech_start[gi]),
                .o_busy  (prech_busy[gi])
            );
        end
    endgenerate

    // ************************************************************
    // address latch, column step and refresh row
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            addr_q <= '0;
            step_q <= 1'b0;
        end else begin
            step_q <= step_s;
            if (acc_start) begin
                addr_q <= '{bank: bank_s, row: row_s, col: col_s};
            end else if (step_s && !step_q && state_q != S_IDLE) begin
                addr_q.col <= addr_q.col + 1'b1;
            end
        end
    end

    // refresh row advances as each refresh starts
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ref_row_q <= '0;
        end else if (ref_start) begin
            ref_row_q <= ref_row_q + 1'b1;
        end
    end

    // fall-through passes the live column; column steps need the latch
    wire [ADDR_W-1:0] col_use = cfg_q.fall_through ? col_s : addr_q.col;
    wire [ADDR_W-1:0] row_use = cfg_q.fall_through ? row_s : addr_q.row;

    // ************************************************************
    // dram drivers
    // ************************************************************
    wire cas_phase = (state_q == S_HOLD);
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_dram_addr <= '0;
            o_ras_n     <= 4'hF;
            o_cas_n     <= 4'hF;
        end else begin
            o_ras_n <= (state_q == S_ROW && tcnt_q != '0) ? 4'hF : ~ras_sel_q;
            if (state_q == S_REF) begin
                o_dram_addr <= ref_row_q;
                // scrubbing refresh also reads a column to correct the word
                o_cas_n <= (cfg_q.ref_type[1]) ? ~ras_sel_q : 4'hF;
            end else begin
                o_dram_addr <= (state_q == S_COL || cas_phase) ? col_use : row_use;
                o_cas_n     <= cas_phase ? ~(ras_sel_q & ~cas_enable_in_n_s) : 4'hF;
            end
        end
    end

    // ************************************************************
    // host wait, acknowledge and status
    // ************************************************************
    // ready only once the column phase is reached and the host is not extending
    wire ready = cas_phase && !wext_s;
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_transfer_ack_out <= 1'b0;
            o_wait_n           <= 1'b1;
            o_refresh_ack      <= 1'b0;
            o_grant_b          <= 1'b0;
        end else begin
            o_transfer_ack_out <= cfg_q.ack_form & ready & !port_b_q;
            o_wait_n           <= cfg_q.ack_form | ready | !req_a_s | port_b_q;
            o_refresh_ack      <= (state_q == S_REF) && cfg_q.reqack_ref;
            o_grant_b          <= port_b_q && state_q != S_IDLE;
        end
    end

    assign o_programmed = programmed_q;
    assign o_init_busy  = init_busy_q;

endmodule // dram_access_refresh_controller

// ==== dram_ctrl_chk.sv ====
// checker: timing relations at the controller ports
`timescale 1ns/1ns
module dram_ctrl_chk
    import dram_ctrl_pkg::*;
#(
    parameter int unsigned INIT_COUNT = INIT_CYCLES
) (
    // clock and reset
    input wire logic             i_mclk,
    input wire logic             i_srst,
    // watched signals
    input wire logic             i_wait_extend_in,
    input wire logic             o_transfer_ack_out,
    input wire logic             o_grant_b,
    input wire logic [BANKS-1:0] o_ras_n,
    input wire logic [BANKS-1:0] o_cas_n,
    input wire logic             o_programmed,
    input wire logic             o_init_busy
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    logic        done_q;
    int unsigned bcnt_q;
    // init length counter; done flag catches a second init without reset
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            done_q <= 1'b0;
            bcnt_q <= 0;
        end else begin
            if ($fell(o_init_busy)) done_q <= 1'b1;
            bcnt_q <= o_init_busy ? bcnt_q + 1 : 0;
        end
    end
    // ************************************************************
    // assertions
    // ************************************************************
    chk_unprog_no_cas: assert property (!o_programmed |-> o_cas_n == 4'hF)
        else $error("cas low before first load");
    chk_init_no_ack: assert property (o_init_busy |-> !o_transfer_ack_out)
        else $error("ack during init period");
    chk_init_length: assert property ($fell(o_init_busy) |->
        bcnt_q + 2 >= INIT_COUNT && bcnt_q <= INIT_COUNT + 2)
        else $error("init period length off");
    chk_init_once: assert property (done_q |-> !o_init_busy)
        else $error("init restarted without reset");
    chk_prog_kept: assert property (o_programmed |=> o_programmed)
        else $error("configuration lost");
    chk_ras_precharge: assert property ($rose(o_ras_n[0]) |-> o_ras_n[0] [*5])
        else $error("precharge too short");
    chk_refresh_low: assert property ($fell(o_ras_n[0]) && o_init_busy |-> !o_ras_n[0] [*6])
        else $error("refresh row strobe too short");
    chk_extend_holds: assert property (i_wait_extend_in [*4] |-> !$rose(o_transfer_ack_out))
        else $error("ack despite wait extend");
    chk_ack_in_access: assert property (o_transfer_ack_out |-> o_ras_n != 4'hF)
        else $error("ack without row strobe");
    chk_cas_with_ras: assert property (o_cas_n != 4'hF |-> o_ras_n != 4'hF)
        else $error("cas without row strobe");
    chk_grant_excl: assert property (o_grant_b |-> !o_transfer_ack_out)
        else $error("port a acked while b granted");
endmodule // dram_ctrl_chk

// ==== dram_ctrl_pkg.sv ====
// package: constants, enums and carrier structs of the dram access and refresh controller
package dram_ctrl_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLK_MHZ           = 100;
    localparam int unsigned INIT_PERIOD_MS    = 60;
    localparam int unsigned INIT_CYCLES       = INIT_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int unsigned REFRESH_INTERVAL  = 1560;
    localparam int unsigned RAS_LOW_CYCLES    = 6;
    localparam int unsigned PRECHARGE_CYCLES  = 5;
    localparam int unsigned CAS_DELAY_CYCLES  = 2;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned ADDR_W   = 11;
    localparam int unsigned BANKS    = 4;
    localparam int unsigned PCNT_W   = 4;

    // ************************************************************
    // configuration word layout, row inputs and bank selects during loading
    // ************************************************************
    localparam int unsigned CFG_ACCESS_MODE_BIT = 0;
    localparam int unsigned CFG_WAIT_ACK_BIT    = 1;
    localparam int unsigned CFG_FALL_THRU_BIT   = 2;
    localparam int unsigned CFG_AUTO_REF_BIT    = 3;
    localparam int unsigned CFG_EXT_REF_BIT     = 4;
    localparam int unsigned CFG_REQACK_REF_BIT  = 5;
    localparam int unsigned CFG_REF_TYPE_LSB    = 6;
    localparam int unsigned CFG_BANK_CFG_LSB    = 8;

    // reset value of the configuration: mode 0, wait form, latched, auto refresh
    localparam logic [9:0] CFG_RESET = 10'h040;

    typedef enum logic [1:0] { BANKCFG_ONE, BANKCFG_TWO, BANKCFG_FOUR, BANKCFG_FOUR_ALT } bank_cfg_t;
    typedef enum logic [1:0] { REF_CONVENTIONAL, REF_PHASED, REF_SCRUB, REF_SCRUB_ALT } ref_type_t;

    // decoded configuration
    typedef struct packed {
        logic      access_mode1;
        logic      ack_form;
        logic      fall_through;
        logic      auto_ref;
        logic      ext_ref;
        logic      reqack_ref;
        ref_type_t ref_type;
        bank_cfg_t bank_cfg;
    } cfg_t;

    // latched host address
    typedef struct packed {
        logic [1:0]        bank;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
    } haddr_t;

endpackage

// ==== host_bus_model.sv ====
// host bus model: one port-a request per go pulse
`timescale 1ns/1ns
module host_bus_model (
    // clock
    input  wire logic       i_mclk,
    // bench control
    input  wire logic       i_go,
    input  wire logic [3:0] i_hold,
    // controller answer
    input  wire logic       i_ready,
    output logic            o_req
);
    int n;
    // request stands until ready is sampled, then i_hold more cycles;
    // a give-up count stops a refused request from hanging the host
    initial begin
        o_req = 1'b0;
        forever begin
            @(posedge i_mclk);
            if (i_go === 1'b1) begin
                #1 o_req = 1'b1;
                n = 0;
                do begin
                    @(posedge i_mclk);
                    n++;
                end while (n < 99 && i_ready !== 1'b1);
                repeat (i_hold) @(posedge i_mclk);
                #1 o_req = 1'b0;
            end
        end
    end
endmodule // host_bus_model

// ==== precharge_counter.sv ====
// one bank's precharge down counter
`timescale 1ns/1ns
module precharge_counter
    import dram_ctrl_pkg::*;
#(
    parameter int unsigned CYCLES = PRECHARGE_CYCLES
) (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_srst,
    // control
    input  wire logic i_start,
    output logic      o_busy
);

    logic [PCNT_W-1:0] cnt_q;

    // ************************************************************
    // count
    // ************************************************************
    // reloads on start, a clock before the bank's row strobe rises, runs down to zero
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            cnt_q <= '0;
        end else if (i_start) begin
            cnt_q <= PCNT_W'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - PCNT_W'(1);
        end
    end

    assign o_busy = (cnt_q != '0);

endmodule // precharge_counter

// ==== test_dram_access_refresh_controller.sv ====
// testbench: programming, access and refresh scenarios
`timescale 1ns/1ns
module test_dram_access_refresh_controller
    import dram_ctrl_pkg::*;
;
    localparam int unsigned INIT_N = 200;
    logic                   mclk, srst, load_n, req_b, step, wext, ext_ref, ref_req, go, bs_lo, bs_hi;
    logic [ADDR_W-1:0]      row, col;
    logic [3:0]             cas_enable_in_n, hold;
    wire logic              req_a, ref_ack, ack, wait_n, grant_b, prog, init_busy;
    wire logic [ADDR_W-1:0] dram_addr;
    wire logic [BANKS-1:0]  ras_n, cas_n;
    int                     bad_count, checked, n, d0, d1;
    // chip select tied: it has no effect on loading
    dram_access_refresh_controller #(.INIT_COUNT(INIT_N), .REFRESH_COUNT(50)) u_dram_access_refresh_controller (
        .i_mclk(mclk), .i_srst(srst), .i_row_addr(row), .i_col_addr(col),
        .i_bank_select_lo(bs_lo), .i_bank_select_hi(bs_hi), .i_config_load_strobe_n(load_n),
        .i_chip_select_n(1'b1), .i_access_req_a(req_a), .i_access_req_b(req_b),
        .i_column_step_in(step), .i_cas_enable_in_n(cas_enable_in_n), .i_wait_extend_in(wext),
        .i_ext_refresh_req(ext_ref), .i_refresh_req_in(ref_req), .o_refresh_ack(ref_ack),
        .o_transfer_ack_out(ack), .o_wait_n(wait_n), .o_grant_b(grant_b), .o_dram_addr(dram_addr),
        .o_ras_n(ras_n), .o_cas_n(cas_n), .o_programmed(prog), .o_init_busy(init_busy));
    host_bus_model u_host_bus_model (.i_mclk(mclk), .i_go(go), .i_hold(hold), .i_ready(ack), .o_req(req_a));
    // ************************************************************
    // helpers
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic give_verdict;
        if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // inputs always change 1 ns after the edge
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic load(input logic [9:0] w);
        row = {3'h0, w[7:0]};
        {bs_hi, bs_lo} = w[9:8];
        load_n = 1'b0;
        tick(4);
        load_n = 1'b1;
        tick(4);
    endtask
    // starts an access and checks the answer; dly is request to row strobe
    task automatic access(input logic [3:0] h, output int dly);
        row = 11'h0A5;
        col = 11'h35A;
        hold = h;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (dly = 0; dly < 40 && ras_n === 4'hF; dly++) tick(1);
        for (n = 0; n < 40 && ack !== 1'b1; n++) tick(1);
        cmp(ack, 1'b1);
        cmp(dram_addr, col);
        cmp(cas_n, cas_enable_in_n);
    endtask
    task automatic settle;
        for (n = 0; n < 150 && req_a === 1'b1; n++) tick(1);
        tick(8);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_unprog;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(30);
        cmp({ack, prog, cas_n}, {2'b00, 4'hF});
        settle();
    endtask
    task automatic t_init;
        row = 11'h00A;
        load_n = 1'b0;
        for (n = 0; n < 400 && init_busy !== 1'b1; n++) tick(1);
        load_n = 1'b1;
        for (n = n; n < 400 && init_busy === 1'b1; n++) tick(1);
        cmp(n >= INIT_N && n <= INIT_N + 8, 1'b1);
        load(10'h00A);
        tick(10);
        cmp({prog, init_busy}, 2'b10);
    endtask
    task automatic t_modes;
        access(0, d0);
        settle();
        load(10'h00B);
        access(0, d1);
        settle();
        cmp(d0 - d1, 1);
        access(12, d1);
        step = 1'b1;
        tick(1);
        step = 1'b0;
        tick(5);
        cmp(dram_addr, col + 11'h001);
        settle();
    endtask
    task automatic t_wait;
        load(10'h00A);
        wext = 1'b1;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(30);
        cmp(ack, 1'b0);
        wext = 1'b0;
        for (n = 0; n < 40 && ack !== 1'b1; n++) tick(1);
        cmp(ack, 1'b1);
        settle();
        load(10'h008);
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (n = 0; n < 30 && wait_n !== 1'b0; n++) tick(1);
        cmp(wait_n, 1'b0);
        for (n = 0; n < 30 && wait_n !== 1'b1; n++) tick(1);
        cmp({wait_n, ack}, 2'b10);
        settle();
    endtask
    task automatic t_refresh;
        for (int ty = 0; ty < 3; ty++) begin
            load(10'h022 | 10'(ty << 6));
            ref_req = 1'b1;
            for (n = 0; n < 40 && ref_ack !== 1'b1; n++) tick(1);
            cmp(ref_ack, 1'b1);
            ref_req = 1'b0;
            tick(20);
        end
        load(10'h012);
        ext_ref = 1'b1;
        for (n = 0; n < 40 && ras_n === 4'hF; n++) tick(1);
        cmp(ras_n !== 4'hF, 1'b1);
        ext_ref = 1'b0;
        tick(30);
        load(10'h00A);
        for (n = 0; n < 80 && ras_n === 4'hF; n++) tick(1);
        cmp(ras_n !== 4'hF, 1'b1);
        tick(20);
        req_b = 1'b1;
        for (n = 0; n < 30 && grant_b !== 1'b1; n++) tick(1);
        cmp(grant_b, 1'b1);
        req_b = 1'b0;
        tick(20);
    endtask
    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        {srst, load_n, req_b, step, wext, ext_ref, ref_req, go, bs_lo, bs_hi} = 10'h300;
        row = 11'h000;
        col = 11'h000;
        cas_enable_in_n = 4'h5;
        hold = 4'h0;
        tick(4);
        srst = 1'b0;
        t_unprog();
        t_init();
        t_modes();
        t_wait();
        t_refresh();
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        cmp(prog, 1'b0);
        load(10'h00A);
        cmp(init_busy, 1'b1);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        give_verdict();
    end
endmodule // test_dram_access_refresh_controller
bind dram_access_refresh_controller dram_ctrl_chk #(.INIT_COUNT(INIT_COUNT)) u_dram_ctrl_chk (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_wait_extend_in(i_wait_extend_in),
    .o_transfer_ack_out(o_transfer_ack_out), .o_grant_b(o_grant_b), .o_ras_n(o_ras_n),
    .o_cas_n(o_cas_n), .o_programmed(o_programmed), .o_init_busy(o_init_busy));
